// ### dfcs_core_model.sv
// Purpose: core model that issues command sequencer register writes
// Assumes: writes launched on the falling clock edge
// Notes: idles while stalled, as the real core would
`timescale 1ns/1ps
`default_nettype none
module dfcs_core_model
  import dfcs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_stall,
  output var dfcs_sfr_wr_t o_sfr_wr
);
  // ==========================================================
  // register write cycle
  initial o_sfr_wr = '0;

  task automatic wr(input dfcs_sel_t sel, input logic [7:0] data);
    @(negedge i_ref_clk);
    while (i_stall !== 1'b0) @(negedge i_ref_clk);
    o_sfr_wr = '{en: 1'b1, sel: sel, data: data};
    @(negedge i_ref_clk);
    // released lines flip so stale data never looks valid
    o_sfr_wr = '{en: 1'b0, sel: sel, data: ~data};
  endtask : wr

  // ==========================================================
  // address loaded before command
  task automatic page_cmd(input logic [15:0] addr, input logic [7:0] cmd);
    wr(SEL_ADDR_HI, addr[15:8]);
    wr(SEL_ADDR_LO, addr[7:0]);
    wr(SEL_CMD, cmd);
  endtask : page_cmd
endmodule : dfcs_core_model
`default_nettype wire

// ### dfcs_pkg.sv
// Purpose: shared constants and types for the data flash command sequencer
// Assumes: 200 MHz core clock, 12 clocks per machine cycle
// Notes: long durations become top-level parameters
package dfcs_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned MC_CLKS = 12;
  localparam int unsigned RD_PAGE_MC = 5;
  localparam int unsigned RD_BYTE_MC = 3;
  localparam int unsigned T_PROG_PAGE_US = 380;
  localparam int unsigned T_ERASE_US = 2000;
  localparam int unsigned T_PROG_BYTE_US = 200;
  localparam int unsigned T_PM_PROG_PAGE_US = 15000;
  localparam int unsigned CYC_RD_PAGE = RD_PAGE_MC * MC_CLKS;
  localparam int unsigned CYC_RD_BYTE = RD_BYTE_MC * MC_CLKS;
  localparam int unsigned CYC_PROG_PAGE = T_PROG_PAGE_US * CLK_MHZ;
  localparam int unsigned CYC_ERASE = T_ERASE_US * CLK_MHZ;
  localparam int unsigned CYC_PROG_BYTE = T_PROG_BYTE_US * CLK_MHZ;
  localparam int unsigned CYC_PM_PROG_PAGE = T_PM_PROG_PAGE_US * CLK_MHZ;
  localparam int unsigned CNT_W = 24;
  // ==========================================================
  // command codes and reset values
  localparam logic [7:0] CMD_PAGE_READ = 8'h01;
  localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
  localparam logic [7:0] CMD_PAGE_COMPARE = 8'h04;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h05;
  localparam logic [7:0] CMD_FULL_ERASE = 8'h06;
  localparam logic [7:0] CMD_BYTE_READ = 8'h81;
  localparam logic [7:0] CMD_BYTE_PROG = 8'h82;
  localparam logic [7:0] CMD_LEAVE_DL = 8'h0F;
  localparam logic [7:0] CMD_ENTER_DL = 8'hF0;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [7:0] BYTE_ERASED = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int unsigned MEM_BYTES = 4096;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    SEL_CMD, SEL_BUF0, SEL_BUF1, SEL_BUF2, SEL_BUF3, SEL_ADDR_HI, SEL_ADDR_LO
  } dfcs_sel_t;
  typedef struct packed {
    logic en;
    dfcs_sel_t sel;
    logic [7:0] data;
  } dfcs_sfr_wr_t;
  typedef logic [3:0][7:0] dfcs_page_t;
  typedef enum logic [2:0] {
    OP_NONE, OP_RD_PAGE, OP_PROG_PAGE, OP_VERIFY, OP_ERASE_PAGE,
    OP_ERASE_ALL, OP_RD_BYTE, OP_PROG_BYTE
  } dfcs_op_t;
  typedef struct packed {
    logic valid;
    dfcs_op_t op;
    logic [15:0] addr;
  } dfcs_pm_op_t;

  function automatic logic [CNT_W-1:0] dfcs_last(input int unsigned cyc);
    return CNT_W'(cyc - 1);
  endfunction : dfcs_last
endpackage : dfcs_pkg

// ### dfcs_sequencer.sv
// Purpose: data flash command sequencer with download-mode timing
// Assumes: core writes one register per cycle through i_sfr_wr
// Notes: data array held in flops; program memory is outside
// Contract
// - a byte is programmed only while it still holds all ones.
// - erase clears a whole four-byte page at least.
// - code 4 compares buffers to page; command reads zero on match.
// - erase-all code clears the whole 4 KB array, about 2 ms.
// - the operation starts right at the command write.
// - the core is held until the operation finishes.
// - no interrupt service while an operation runs.
// - timers and counters keep running during the stall.
// - page read and compare take 5 machine cycles, byte read 3.
// - data mode: page program 380 us, erases 2 ms, byte 200 us.
// - download mode: page 15 ms, erases 2 ms, byte 200 us.
// - 81 reads a byte into buffer one, 82 programs it.
// - F0 enters download mode, 0F leaves it; 03 is reserved.
`timescale 1ns/1ps
`default_nettype none
module dfcs_sequencer
  import dfcs_pkg::*;
#(
  parameter int unsigned P_PROG_PAGE_CLKS = CYC_PROG_PAGE,
  parameter int unsigned P_ERASE_CLKS = CYC_ERASE,
  parameter int unsigned P_PROG_BYTE_CLKS = CYC_PROG_BYTE,
  parameter int unsigned P_PM_PROG_PAGE_CLKS = CYC_PM_PROG_PAGE
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire dfcs_sfr_wr_t i_sfr_wr,
  output logic [7:0] o_cmd_readback,
  output dfcs_page_t o_page_buf,
  output logic [15:0] o_page_addr,
  output logic o_dl_mode,
  output logic o_stall,
  output logic o_irq_hold,
  output dfcs_pm_op_t o_pm_op
);
  default clocking dfcs_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);
  // ==========================================================
  // state
  typedef enum logic {ST_IDLE, ST_BUSY} dfcs_state_t;
  dfcs_state_t state_q, state_d;
  dfcs_op_t op_q, op_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0] cmd_q, cmd_d;
  dfcs_page_t buf_q, buf_d;
  logic [15:0] addr_q, addr_d;
  logic dl_q, dl_d;
  dfcs_pm_op_t pm_q, pm_d;
  logic [7:0] mem_q [MEM_BYTES];
  logic done;
  logic [11:0] pg_base;
  logic [11:0] byte_addr;
  logic match;

  assign pg_base = {addr_q[9:0], 2'b00};
  assign byte_addr = addr_q[11:0];
  assign done = (state_q == ST_BUSY) && (cnt_q == '0);
  assign match = (buf_q[0] == mem_q[pg_base])
    && (buf_q[1] == mem_q[pg_base + 12'd1])
    && (buf_q[2] == mem_q[pg_base + 12'd2])
    && (buf_q[3] == mem_q[pg_base + 12'd3]);

  // ==========================================================
  // next state
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    cnt_d = cnt_q;
    cmd_d = cmd_q;
    buf_d = buf_q;
    addr_d = addr_q;
    dl_d = dl_q;
    pm_d = '0;
    unique case (state_q)
      ST_IDLE: begin
        // writes during a stall cannot come from a held core
        if (i_sfr_wr.en) begin
          unique case (i_sfr_wr.sel)
            SEL_BUF0: buf_d[0] = i_sfr_wr.data;
            SEL_BUF1: buf_d[1] = i_sfr_wr.data;
            SEL_BUF2: buf_d[2] = i_sfr_wr.data;
            SEL_BUF3: buf_d[3] = i_sfr_wr.data;
            SEL_ADDR_HI: addr_d[15:8] = i_sfr_wr.data;
            SEL_ADDR_LO: addr_d[7:0] = i_sfr_wr.data;
            default: begin
              cmd_d = i_sfr_wr.data;
              op_d = OP_NONE;
              unique case (i_sfr_wr.data)
                CMD_PAGE_READ: if (!dl_q) begin
                  op_d = OP_RD_PAGE;
                  cnt_d = dfcs_last(CYC_RD_PAGE);
                end
                CMD_PAGE_COMPARE: if (!dl_q) begin
                  op_d = OP_VERIFY;
                  cnt_d = dfcs_last(CYC_RD_PAGE);
                end
                CMD_BYTE_READ: if (!dl_q) begin
                  op_d = OP_RD_BYTE;
                  cnt_d = dfcs_last(CYC_RD_BYTE);
                end
                CMD_PAGE_PROG: begin
                  op_d = OP_PROG_PAGE;
                  cnt_d = dl_q ? dfcs_last(P_PM_PROG_PAGE_CLKS)
                               : dfcs_last(P_PROG_PAGE_CLKS);
                end
                CMD_PAGE_ERASE: begin
                  op_d = OP_ERASE_PAGE;
                  cnt_d = dfcs_last(P_ERASE_CLKS);
                end
                CMD_FULL_ERASE: begin
                  op_d = OP_ERASE_ALL;
                  cnt_d = dfcs_last(P_ERASE_CLKS);
                end
                CMD_BYTE_PROG: begin
                  op_d = OP_PROG_BYTE;
                  cnt_d = dfcs_last(P_PROG_BYTE_CLKS);
                end
                CMD_ENTER_DL: dl_d = 1'b1;
                CMD_LEAVE_DL: dl_d = 1'b0;
                default: op_d = OP_NONE;
              endcase
              if (op_d != OP_NONE) begin
                state_d = ST_BUSY;
              end
            end
          endcase
        end
      end
      ST_BUSY: begin
        if (done) begin
          state_d = ST_IDLE;
          pm_d = '{valid: dl_q, op: op_q, addr: addr_q};
          if (!dl_q) begin
            unique case (op_q)
              OP_RD_PAGE: begin
                buf_d[0] = mem_q[pg_base];
                buf_d[1] = mem_q[pg_base + 12'd1];
                buf_d[2] = mem_q[pg_base + 12'd2];
                buf_d[3] = mem_q[pg_base + 12'd3];
              end
              OP_RD_BYTE: buf_d[0] = mem_q[byte_addr];
              OP_VERIFY: cmd_d = match ? BYTE_ZERO : cmd_q;
              default: cmd_d = cmd_q;
            endcase
          end
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_q <= ST_IDLE;
      op_q <= OP_NONE;
      cnt_q <= '0;
      cmd_q <= CMD_RST;
      buf_q <= '0;
      addr_q <= '0;
      dl_q <= 1'b0;
      pm_q <= '0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
      buf_q <= buf_d;
      addr_q <= addr_d;
      dl_q <= dl_d;
      pm_q <= pm_d;
    end
  end

  // ==========================================================
  // array; contents survive reset like real nonvolatile cells
  always_ff @(posedge i_ref_clk) begin
    if (!i_srst && done && !dl_q) begin
      unique case (op_q)
        OP_ERASE_PAGE: for (int i = 0; i < 4; i++) begin
          mem_q[pg_base + 12'(i)] <= BYTE_ERASED;
        end
        OP_ERASE_ALL: for (int i = 0; i < MEM_BYTES; i++) begin
          mem_q[i] <= BYTE_ERASED;
        end
        OP_PROG_PAGE: for (int i = 0; i < 4; i++) begin
          if (mem_q[pg_base + 12'(i)] == BYTE_ERASED) begin
            mem_q[pg_base + 12'(i)] <= buf_q[i];
          end
        end
        OP_PROG_BYTE: if (mem_q[byte_addr] == BYTE_ERASED) begin
          mem_q[byte_addr] <= buf_q[0];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // outputs
  // core held while busy
  assign o_stall = (state_q == ST_BUSY);
  // interrupts held off for the same span
  // stall gates the core only, never peripheral clocks
  assign o_irq_hold = (state_q == ST_BUSY);
  assign o_cmd_readback = cmd_q;
  assign o_page_buf = buf_q;
  assign o_page_addr = addr_q;
  assign o_dl_mode = dl_q;
  assign o_pm_op = pm_q;

  // ==========================================================
  // checks
  logic [CNT_W-1:0] span_q;
  logic [CNT_W-1:0] want_q;
  logic [7:0] old_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      span_q <= '0;
      want_q <= '0;
    end else begin
      span_q <= o_stall ? span_q + CNT_W'(1) : '0;
      if (state_q == ST_IDLE && state_d == ST_BUSY) begin
        want_q <= cnt_d + CNT_W'(1);
      end
    end
    old_q <= mem_q[byte_addr];
  end

  a_stall_span_len: assert property (
    $fell(o_stall) |-> span_q == want_q)
    else $error("stall length differs from op duration");
  a_read_page_len: assert property (
    $fell(o_stall) && op_q == OP_RD_PAGE |-> span_q == CNT_W'(CYC_RD_PAGE))
    else $error("page read not five machine cycles");
  a_cmd_starts_op: assert property (
    !o_stall && i_sfr_wr.en && i_sfr_wr.sel == SEL_CMD
    && i_sfr_wr.data == CMD_FULL_ERASE |=> o_stall)
    else $error("command did not start at once");
  a_reserved_idle: assert property (
    !o_stall && i_sfr_wr.en && i_sfr_wr.sel == SEL_CMD
    && i_sfr_wr.data == 8'h03 |=> !o_stall && $stable(o_page_buf))
    else $error("reserved code had an effect");
  a_irq_with_stall: assert property (
    o_irq_hold == o_stall)
    else $error("interrupt hold differs from stall");
  a_erase_page_ff: assert property (
    done && !dl_q && op_q == OP_ERASE_PAGE
    |=> mem_q[pg_base] == BYTE_ERASED && mem_q[pg_base + 12'd3] == BYTE_ERASED)
    else $error("page not erased");
  a_prog_needs_erase: assert property (
    done && !dl_q && op_q == OP_PROG_BYTE && mem_q[byte_addr] != BYTE_ERASED
    |=> mem_q[byte_addr] == old_q)
    else $error("programmed a byte that was not erased");
  a_verify_result: assert property (
    done && !dl_q && op_q == OP_VERIFY
    |=> (o_cmd_readback == BYTE_ZERO) == $past(match))
    else $error("compare result wrong");
  a_byte_read_buf: assert property (
    done && !dl_q && op_q == OP_RD_BYTE |=> o_page_buf[0] == old_q)
    else $error("byte read wrong");
  a_dl_enter: assert property (
    !o_stall && i_sfr_wr.en && i_sfr_wr.sel == SEL_CMD
    && i_sfr_wr.data == CMD_ENTER_DL |=> o_dl_mode)
    else $error("download mode not entered");

  c_verify_pass: cover property (done && op_q == OP_VERIFY && match);
  c_page_prog: cover property (done && op_q == OP_PROG_PAGE && !dl_q);
  c_dl_prog: cover property (o_pm_op.valid);
endmodule : dfcs_sequencer
`default_nettype wire

// ### tb.sv
// Purpose: self-checking bench for the data flash command sequencer
// Assumes: short duration parameters 20, 30, 10, 40 clocks
// Notes: stall lengths counted on falling edges
`timescale 1ns/1ps
`default_nettype none
module tb
  import dfcs_pkg::*;
;
  // ==========================================================
  // setup
  localparam int unsigned PP = 20, ER = 30, PB = 10, PM = 40;
  localparam int unsigned SKIP = 32'hFFFF_FFFF;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  dfcs_sfr_wr_t sfr_wr;
  logic [7:0] cmd_rb;
  dfcs_page_t page_buf, pg;
  logic [15:0] page_addr;
  logic dl_mode, stall, irq_hold;
  dfcs_pm_op_t pm_op;
  dfcs_pm_op_t pm_last = '0;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int pm_cnt = 0;

  always #2.5 i_ref_clk = ~i_ref_clk;

  dfcs_sequencer #(.P_PROG_PAGE_CLKS(PP), .P_ERASE_CLKS(ER),
    .P_PROG_BYTE_CLKS(PB), .P_PM_PROG_PAGE_CLKS(PM)) dfcs_sequencer_i (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_sfr_wr(sfr_wr),
    .o_cmd_readback(cmd_rb), .o_page_buf(page_buf),
    .o_page_addr(page_addr), .o_dl_mode(dl_mode), .o_stall(stall),
    .o_irq_hold(irq_hold), .o_pm_op(pm_op));

  dfcs_core_model dfcs_core_model_i (.i_ref_clk(i_ref_clk),
    .i_stall(stall), .o_sfr_wr(sfr_wr));

  always @(posedge i_ref_clk) begin
    if (pm_op.valid === 1'b1) begin
      pm_cnt <= pm_cnt + 1;
      pm_last <= pm_op;
    end
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic run(input logic [15:0] addr, input logic [7:0] code,
                     input int unsigned len);
    int unsigned n;
    n = 0;
    dfcs_core_model_i.page_cmd(addr, code);
    while (stall === 1'b1 && n < 100) begin
      check("irq_hold", irq_hold, 32'h1);
      n++;
      @(negedge i_ref_clk);
    end
    if (len != SKIP) check("stall_len", n, len);
  endtask : run

  task automatic load(input dfcs_page_t p);
    for (int i = 0; i < 4; i++)
      dfcs_core_model_i.wr(dfcs_sel_t'(3'(i + 1)), p[i]);
  endtask : load

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // scenarios
  task automatic t_reset();
    check("rst_cmd", cmd_rb, 32'h0);
    check("rst_buf", page_buf, 32'h0);
    check("rst_stall", {page_addr, 7'h00, dl_mode, 7'h00, stall}, 32'h0);
  endtask : t_reset

  task automatic t_erase_all();
    run(16'h0000, CMD_FULL_ERASE, ER);
    run(16'h03FF, CMD_PAGE_READ, CYC_RD_PAGE);
    check("top_page", page_buf, 32'hFFFF_FFFF);
    dfcs_core_model_i.wr(SEL_BUF0, 8'h00);
    run(16'h0FFF, CMD_BYTE_READ, CYC_RD_BYTE);
    check("last_byte", page_buf[0], 32'hFF);
  endtask : t_erase_all

  task automatic t_update();
    pg = {8'h44, 8'h33, 8'hF3, 8'h11};
    run(16'h0003, CMD_PAGE_ERASE, ER);
    load(pg);
    run(16'h0003, CMD_PAGE_PROG, PP);
    load(~pg);
    run(16'h0003, CMD_PAGE_READ, CYC_RD_PAGE);
    check("page_rd", page_buf, pg);
    load(pg);
    run(16'h0003, CMD_PAGE_COMPARE, CYC_RD_PAGE);
    check("cmp_ok", cmd_rb, 32'h0);
    dfcs_core_model_i.wr(SEL_BUF2, 8'h00);
    run(16'h0003, CMD_PAGE_COMPARE, CYC_RD_PAGE);
    check("cmp_bad", cmd_rb, 32'h04);
    run(16'h0003, CMD_PAGE_ERASE, ER);
    run(16'h0003, CMD_PAGE_READ, CYC_RD_PAGE);
    check("erased_pg", page_buf, 32'hFFFF_FFFF);
  endtask : t_update

  task automatic t_byte();
    dfcs_core_model_i.wr(SEL_BUF0, 8'hA5);
    run(16'h000D, CMD_BYTE_PROG, PB);
    dfcs_core_model_i.wr(SEL_BUF0, 8'h5A);
    run(16'h000D, CMD_BYTE_PROG, PB);
    run(16'h000D, CMD_BYTE_READ, CYC_RD_BYTE);
    check("byte_rd", page_buf[0], 32'hA5);
  endtask : t_byte

  task automatic t_reserved();
    run(16'h000D, 8'h03, 0);
    check("rsv_cmd", cmd_rb, 32'h03);
    dfcs_core_model_i.wr(SEL_ADDR_LO, 8'h2C);
    dfcs_core_model_i.wr(SEL_CMD, 8'hAA);
    check("rsv_stall", stall, 32'h0);
    check("rsv_buf", page_buf, 32'hFFFF_FFA5);
    check("rsv_addr", page_addr, 32'h002C);
  endtask : t_reserved

  task automatic t_download();
    int c0;
    run(16'h0003, CMD_ENTER_DL, 0);
    check("dl_on", dl_mode, 32'h1);
    c0 = pm_cnt;
    run(16'h1200, CMD_PAGE_PROG, PM);
    repeat (2) @(negedge i_ref_clk);
    check("pm_pulses", pm_cnt - c0, 32'h1);
    check("pm_op", {pm_last.op, pm_last.addr}, {OP_PROG_PAGE, 16'h1200});
    run(16'h1240, CMD_PAGE_ERASE, ER);
    run(16'h0000, CMD_FULL_ERASE, ER);
    run(16'h1201, CMD_BYTE_PROG, PB);
    run(16'h0003, CMD_PAGE_READ, 0);
    run(16'h0003, CMD_LEAVE_DL, 0);
    check("dl_off", dl_mode, 32'h0);
    run(16'h0003, CMD_PAGE_READ, CYC_RD_PAGE);
    check("dm_intact", page_buf, 32'hFFFF_A5FF);
  endtask : t_download

  // ==========================================================
  // main sequence and hang guard
  initial begin
    repeat (3) @(negedge i_ref_clk);
    i_srst = 1'b0;
    t_reset();
    t_erase_all();
    t_update();
    t_byte();
    t_reserved();
    t_download();
    give_verdict();
  end

  // limit sized well above the under one thousand cycles the run needs
  initial begin
    forever begin
      @(posedge i_ref_clk);
      cycles++;
      if (cycles >= 20000) begin
        miscompares++;
        $display("Error timeout expected done seen hang");
        give_verdict();
      end
    end
  end
endmodule : tb
`default_nettype wire
